// File: hw/uart_frame_defines.vh
// Register offsets, field positions, reset values and timing figures of the UART frame engine.
`ifndef UART_FRAME_DEFINES_VH
`define UART_FRAME_DEFINES_VH
// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define REG_CTRL 5'h00
`define REG_BAUD 5'h04
`define REG_TXDATA 5'h08
`define REG_RXDATA 5'h0c
`define REG_STATUS 5'h10
`define REG_INT_STAT 5'h14
`define REG_INT_MASK 5'h18
// ***********************************************************************
// Control register fields
// ***********************************************************************
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define CTRL_PAR_EN 2
`define CTRL_PAR_ODD 3
`define CTRL_MAJ3 4
`define CTRL_LSB_WLEN 5
`define CTRL_MSB_WLEN 8
`define CTRL_LSB_STOP 9
`define CTRL_MSB_STOP 11
`define CTRL_LSB_SUB 12
`define CTRL_MSB_SUB 13
`define CTRL_RESET 32'h0000_0103
// ***********************************************************************
// Sub-modes and word lengths
// ***********************************************************************
`define SUB_STD 2'h0
`define SUB_CARD 2'h1
`define SUB_IRDA 2'h2
`define SUB_VNET 2'h3
`define WLEN_MIN 4'h4
`define WLEN_MAX 4'h9
// ***********************************************************************
// Interrupt cause bits
// ***********************************************************************
`define INT_TX_DONE 0
`define INT_RX_DONE 1
`define INT_PAR_ERR 2
`define INT_FRAME_ERR 3
`define INT_OVERRUN 4
`define INT_BREAK 5
`define INT_COLLIDE 6
`define INT_BAUD_DET 7
`define INT_W 8
// ***********************************************************************
// Timing figures
// ***********************************************************************
`define CLK_HZ 20000000
`define MAX_BPS 3000000
`define BAUD_RESET 16'h00ae
`define BREAK_BITS 13
`endif

// File: hw/uart_frame_engine.v
// Asynchronous serial frame engine with AXI4-Lite registers.
`timescale 1ns/1ns
`include "uart_frame_defines.vh"
module uart_frame_engine #(
   parameter BAUD_W = 16
) (
   // Clock, reset and enable.
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // AXI4-Lite write address and data.
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response.
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read.
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Serial line.
   output reg txd,
   input wire rxd,
   // Interrupt.
   output wire irq
);
   // ***********************************************************************
   // Register file
   // ***********************************************************************
   reg [31:0] ctrl_r;
   reg [BAUD_W-1:0] baud_r;
   reg [`INT_W-1:0] int_stat_r;
   reg [`INT_W-1:0] int_mask_r;
   reg [8:0] tx_hold_r;
   reg tx_full_r;
   reg [8:0] rx_data_r;
   reg rx_full_r;
   reg [4:0] aw_addr_r;
   reg aw_have_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_have_r;
   reg [BAUD_W-1:0] baud_meas_r;
   wire [`INT_W-1:0] ev;
   wire wr_go;
   wire rd_go;
   wire tx_take;
   wire [3:0] wlen;
   wire [2:0] stop_half;
   wire [1:0] sub_mode;
   wire par_on;
   wire [BAUD_W-1:0] half_bit;
   // Limits word length to the legal range.
   function [3:0] clamp_wlen;
      input [3:0] v;
      begin
         if (v < `WLEN_MIN)
            clamp_wlen = `WLEN_MIN;
         else if (v > `WLEN_MAX)
            clamp_wlen = `WLEN_MAX;
         else
            clamp_wlen = v;
      end
   endfunction
   // Tells whether a byte address maps to a register.
   function mapped;
      input [4:0] a;
      begin
         mapped = (a <= `REG_INT_MASK) && (a[1:0] == 2'h0);
      end
   endfunction
   assign wlen = clamp_wlen(ctrl_r[`CTRL_MSB_WLEN:`CTRL_LSB_WLEN]);
   assign stop_half = ctrl_r[`CTRL_MSB_STOP:`CTRL_LSB_STOP];
   assign sub_mode = ctrl_r[`CTRL_MSB_SUB:`CTRL_LSB_SUB];
   // Parity in standard, smart-card and VNET sub-modes, never in IrDA.
   assign par_on = ctrl_r[`CTRL_PAR_EN] && (sub_mode != `SUB_IRDA);
   assign half_bit = {1'b0, baud_r[BAUD_W-1:1]};
   assign irq = |(int_stat_r & int_mask_r);
   // Address and data are each latched when offered, in either order.
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   // Bus write side, control registers and sticky status.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r <= `CTRL_RESET;
         baud_r <= `BAUD_RESET;
         int_stat_r <= {`INT_W{1'b0}};
         int_mask_r <= {`INT_W{1'b0}};
         tx_hold_r <= 9'h000;
         tx_full_r <= 1'b0;
         aw_addr_r <= 5'h00;
         aw_have_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         w_have_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (tx_take)
            tx_full_r <= 1'b0;
         // Set wins over a write-one clear.
         int_stat_r <= int_stat_r | ev;
         if (wr_go)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_r) ? 2'h0 : 2'h2;
            case (aw_addr_r)
               `REG_CTRL:
               begin
                  if (w_strb_r[0])
                     ctrl_r[7:0] <= w_data_r[7:0];
                  if (w_strb_r[1])
                     ctrl_r[13:8] <= w_data_r[13:8];
               end
               `REG_BAUD:
               begin
                  if (w_strb_r[0])
                     baud_r[7:0] <= w_data_r[7:0];
                  if (w_strb_r[1])
                     baud_r[BAUD_W-1:8] <= w_data_r[BAUD_W-1:8];
               end
               `REG_TXDATA:
               begin
                  if (w_strb_r[0] && !tx_full_r)
                  begin
                     tx_hold_r <= w_data_r[8:0];
                     tx_full_r <= 1'b1;
                  end
               end
               `REG_INT_STAT:
               begin
                  if (w_strb_r[0])
                     int_stat_r <= (int_stat_r & ~w_data_r[`INT_W-1:0]) | ev;
               end
               `REG_INT_MASK:
               begin
                  if (w_strb_r[0])
                     int_mask_r <= w_data_r[`INT_W-1:0];
               end
               default:
               begin
               end
            endcase
         end
      end
   end
   // ***********************************************************************
   // Transmitter
   // ***********************************************************************
   localparam TX_IDLE = 2'h0;
   localparam TX_START = 2'h1;
   localparam TX_BITS = 2'h2;
   localparam TX_STOP = 2'h3;
   reg [1:0] tx_st_r;
   reg [BAUD_W-1:0] tx_cnt_r;
   reg [9:0] tx_sh_r;
   reg [3:0] tx_bits_r;
   reg [3:0] tx_half_r;
   reg tx_done_p_r;
   reg tx_coll_p_r;
   reg [3:0] tx_nbits;
   reg [9:0] tx_frame;
   integer i;
   wire tx_tick;
   assign tx_tick = (tx_cnt_r == {BAUD_W{1'b0}});
   assign tx_take = (tx_st_r == TX_IDLE) && tx_full_r && ctrl_r[`CTRL_TX_EN];
   // Builds the data plus parity word, LSB first, masked to the word length.
   always @*
   begin
      tx_frame = 10'h000;
      for (i = 0; i < 9; i = i + 1)
         if (i < wlen)
            tx_frame[i] = tx_hold_r[i];
      // Parity makes data plus parity even, or odd when selected.
      tx_frame[wlen] = (^tx_frame[8:0]) ^ ctrl_r[`CTRL_PAR_ODD];
      tx_nbits = par_on ? wlen + 4'h1 : wlen;
   end
   // Frame sequencer: start low, data, parity, then half-bit stop steps high.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= {BAUD_W{1'b0}};
         tx_sh_r <= 10'h000;
         tx_bits_r <= 4'h0;
         tx_half_r <= 4'h0;
         txd <= 1'b1;
         tx_done_p_r <= 1'b0;
         tx_coll_p_r <= 1'b0;
      end
      else if (clk_en)
      begin
         tx_done_p_r <= 1'b0;
         // In VNET sub-mode, checks the line mid-bit while driving start, data and parity bits.
         tx_coll_p_r <= (sub_mode == `SUB_VNET) && (tx_st_r != TX_IDLE) &&
            (tx_cnt_r == half_bit) && (rxd != txd);
         if (!tx_tick)
            tx_cnt_r <= tx_cnt_r - 1'b1;
         case (tx_st_r)
            TX_IDLE:
            begin
               txd <= 1'b1;
               if (tx_take)
               begin
                  txd <= 1'b0;
                  tx_sh_r <= tx_frame;
                  tx_bits_r <= tx_nbits;
                  tx_cnt_r <= baud_r - 1'b1;
                  tx_st_r <= TX_START;
               end
            end
            TX_START:
            begin
               if (tx_tick)
               begin
                  txd <= tx_sh_r[0];
                  tx_sh_r <= {1'b0, tx_sh_r[9:1]};
                  tx_bits_r <= tx_bits_r - 4'h1;
                  tx_cnt_r <= baud_r - 1'b1;
                  tx_st_r <= TX_BITS;
               end
            end
            TX_BITS:
            begin
               if (tx_tick)
               begin
                  tx_cnt_r <= baud_r - 1'b1;
                  if (tx_bits_r == 4'h0)
                  begin
                     txd <= 1'b1;
                     tx_half_r <= {1'b0, stop_half} + 4'h1;
                     tx_cnt_r <= half_bit - 1'b1;
                     tx_st_r <= TX_STOP;
                  end
                  else
                  begin
                     txd <= tx_sh_r[0];
                     tx_sh_r <= {1'b0, tx_sh_r[9:1]};
                     tx_bits_r <= tx_bits_r - 4'h1;
                  end
               end
            end
            TX_STOP:
            begin
               // Stop length is (stop_half + 2) half bits: 1 to 4.5, capped by software.
               if (tx_tick)
               begin
                  tx_cnt_r <= half_bit - 1'b1;
                  if (tx_half_r == 4'h0)
                  begin
                     tx_done_p_r <= 1'b1;
                     tx_st_r <= TX_IDLE;
                  end
                  else
                     tx_half_r <= tx_half_r - 4'h1;
               end
            end
            default:
               tx_st_r <= TX_IDLE;
         endcase
      end
   end
   // ***********************************************************************
   // Receiver
   // ***********************************************************************
   localparam RX_IDLE = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_BITS = 2'h2;
   localparam RX_STOP = 2'h3;
   reg [1:0] rx_st_r;
   reg [BAUD_W-1:0] rx_cnt_r;
   reg [2:0] rx_smp_r;
   reg rx_prev_r;
   reg [9:0] rx_sh_r;
   reg [3:0] rx_bits_r;
   reg [4:0] rx_low_r;
   reg [BAUD_W-1:0] low_run_r;
   reg [7:0] rx_ev_r;
   wire rx_bit;
   wire rx_mid;
   wire [9:0] rx_align;
   wire [8:0] rx_keep;
   // Shift history of the line: one sample per cycle.
   always @(posedge aclk)
   begin
      if (!aresetn)
         rx_smp_r <= 3'h7;
      else if (clk_en)
         rx_smp_r <= {rx_smp_r[1:0], rxd};
   end
   // Mid-bit sample or majority of three centred on mid-bit.
   assign rx_bit = ctrl_r[`CTRL_MAJ3] ?
      ((rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[1] & rx_smp_r[2]) |
       (rx_smp_r[0] & rx_smp_r[2])) : rx_smp_r[1];
   assign rx_mid = (rx_cnt_r == {BAUD_W{1'b0}});
   // Moves the first received bit down to bit zero and keeps only the data bits.
   assign rx_align = rx_sh_r >> ((par_on ? 4'h9 : 4'ha) - wlen);
   assign rx_keep = 9'h1ff >> (4'h9 - wlen);
   // Frame receiver; timing restarts at every detected start edge.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= {BAUD_W{1'b0}};
         rx_prev_r <= 1'b1;
         rx_sh_r <= 10'h000;
         rx_bits_r <= 4'h0;
         rx_low_r <= 5'h00;
         rx_data_r <= 9'h000;
         rx_full_r <= 1'b0;
         rx_ev_r <= 8'h00;
         low_run_r <= {BAUD_W{1'b0}};
         baud_meas_r <= {BAUD_W{1'b0}};
      end
      else if (clk_en)
      begin
         rx_ev_r <= 8'h00;
         rx_prev_r <= rx_smp_r[1];
         if (rd_go && s_axi_araddr == `REG_RXDATA)
            rx_full_r <= 1'b0;
         if (!rx_mid)
            rx_cnt_r <= rx_cnt_r - 1'b1;
         // In VNET sub-mode, measures each low run that ends during a frame; the first, after idle, is the bit time of a sync pattern.
         if (!rx_smp_r[1])
            low_run_r <= low_run_r + 1'b1;
         else
         begin
            if (!rx_prev_r && sub_mode == `SUB_VNET && rx_st_r != RX_IDLE)
            begin
               baud_meas_r <= low_run_r;
               rx_ev_r[`INT_BAUD_DET] <= (rx_low_r == 5'h00);
            end
            low_run_r <= {BAUD_W{1'b0}};
         end
         case (rx_st_r)
            RX_IDLE:
            begin
               rx_low_r <= 5'h00;
               if (ctrl_r[`CTRL_RX_EN] && rx_prev_r && !rx_smp_r[1])
               begin
                  rx_cnt_r <= half_bit - 1'b1;
                  rx_st_r <= RX_START;
               end
            end
            RX_START:
            begin
               if (rx_mid)
               begin
                  rx_cnt_r <= baud_r - 1'b1;
                  rx_bits_r <= par_on ? wlen + 4'h1 : wlen;
                  rx_sh_r <= 10'h000;
                  rx_st_r <= rx_bit ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS:
            begin
               if (rx_mid)
               begin
                  rx_cnt_r <= baud_r - 1'b1;
                  rx_sh_r <= {rx_bit, rx_sh_r[9:1]};
                  rx_low_r <= rx_bit ? 5'h1f : rx_low_r + 5'h01;
                  rx_bits_r <= rx_bits_r - 4'h1;
                  if (rx_bits_r == 4'h1)
                     rx_st_r <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               if (rx_mid)
               begin
                  // Bits arrived LSB first into the top; realign to bit zero.
                  rx_data_r <= rx_align[8:0] & rx_keep;
                  rx_full_r <= 1'b1;
                  rx_ev_r[`INT_RX_DONE] <= 1'b1;
                  rx_ev_r[`INT_OVERRUN] <= rx_full_r;
                  rx_ev_r[`INT_PAR_ERR] <= par_on &&
                     ((^rx_sh_r) ^ ctrl_r[`CTRL_PAR_ODD]);
                  rx_ev_r[`INT_FRAME_ERR] <= !rx_bit;
                  // In VNET sub-mode, an all-low frame plus stop is a break once long enough.
                  rx_ev_r[`INT_BREAK] <= !rx_bit && (sub_mode == `SUB_VNET) &&
                     (low_run_r >= baud_r * `BREAK_BITS / 2);
                  rx_st_r <= RX_IDLE;
               end
            end
            default:
               rx_st_r <= RX_IDLE;
         endcase
      end
   end
   assign ev = {rx_ev_r[`INT_BAUD_DET], tx_coll_p_r, rx_ev_r[5:1], tx_done_p_r};
   // ***********************************************************************
   // Bus read side
   // ***********************************************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (clk_en)
      begin
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata <= {18'h00000, ctrl_r[13:0]};
               `REG_BAUD: s_axi_rdata <= {{(32-BAUD_W){1'b0}}, baud_r};
               `REG_TXDATA: s_axi_rdata <= {23'h000000, tx_hold_r};
               `REG_RXDATA: s_axi_rdata <= {23'h000000, rx_data_r};
               `REG_STATUS: s_axi_rdata <= {baud_meas_r, 12'h000, rx_full_r,
                  tx_full_r, (rx_st_r != RX_IDLE), (tx_st_r != TX_IDLE)};
               `REG_INT_STAT: s_axi_rdata <= {24'h000000, int_stat_r};
               `REG_INT_MASK: s_axi_rdata <= {24'h000000, int_mask_r};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   // Clock is always the internal bus clock; 20 MHz over 3 Mbps gives six and two thirds cycles a bit.
endmodule // uart_frame_engine

// File: tb/frame_engine_assertions.sv
// Assertions on the frame engine ports: bus handshakes, reset state and start bits.
`timescale 1ns/1ns
// *****
// Checker
// *****
module frame_engine_checks (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Bus handshakes.
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Line and interrupt.
   input wire txd,
   input wire irq
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Address and data of one write taken on the same edge.
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // The line falls into a start bit and is still low one cycle on.
   sequence s_start;
      $fell(txd) ##1 !txd;
   endsequence
   AST_RESET_IDLE: assert property ($rose(aresetn) |-> txd && !irq)
      else $error("line or interrupt not idle after reset");
   AST_RESET_QUIET: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
      else $error("response pending after reset");
   AST_START_BIT: assert property (s_start |=> !txd)
      else $error("start bit shorter than three cycles");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   AST_B_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response not held");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address accepted while response pending");
endmodule // frame_engine_checks
bind uart_frame_engine frame_engine_checks frame_engine_checks_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .txd, .irq
);

// File: tb/peer_uart_model.sv
// Peer serial port that faces the frame engine on the transmit and receive lines.
`timescale 1ns/1ns
// *****
// Peer model
// *****
module peer_uart_model (
   // Clock.
   input wire aclk,
   // Serial lines.
   input wire line_in,
   output logic line_out
);
   int bit_cyc = 16;
   // The line idles high between frames.
   initial line_out = 1'b1;
   // Sends n bits first to last; bit gb is inverted for one cycle at cycle gc.
   task automatic send(input logic [15:0] bits, input int n, input int gb, input int gc);
      for (int i = 0; i < n; i++)
      begin
         for (int c = 0; c < bit_cyc; c++)
         begin
            line_out <= (i == gb && c == gc) ? ~bits[i] : bits[i];
            @(posedge aclk);
         end
      end
      line_out <= 1'b1;
   endtask
   // Waits for a start edge and samples n bits at their middles.
   task automatic capture(input int n, output logic [15:0] bits);
      bits = 16'h0000;
      while (line_in !== 1'b0) @(negedge aclk);
      repeat (bit_cyc / 2) @(negedge aclk);
      for (int i = 0; i < n; i++)
      begin
         bits[i] = line_in;
         if (i < n - 1) repeat (bit_cyc) @(negedge aclk);
      end
   endtask
endmodule // peer_uart_model

// File: tb/test_uart_standard_frame_engine.sv
// Self-checking bench for the frame engine: bus tasks, serial frames and interrupts.
`timescale 1ns/1ns
`include "uart_frame_defines.vh"
// *****
// Bench
// *****
module test_uart_standard_frame_engine;
   logic aclk;
   logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, v;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire txd, rxd, irq;
   int errors = 0;
   int checked = 0;
   int w, pe, n;
   logic [1:0] r, br;
   logic [15:0] got, f;
   logic [8:0] d;
   logic [15:0] cfg [5] = '{16'h0103, 16'h0287, 16'h1d2f, 16'h26ef, 16'h3103};
   uart_frame_engine uart_frame_engine_i (
      .aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .rxd, .irq
   );
   peer_uart_model peer_uart_model_i (.aclk, .line_in(txd), .line_out(rxd));
   // Clock of 50 ns period.
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Compares one result and counts it.
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      checked++;
      if (a !== e)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   // Expected frame bits, start first, stop bits filling the top.
   function automatic logic [15:0] frame(input logic [8:0] dv, input int wl, input int pb,
      input logic odd);
      logic [15:0] fr;
      fr = 16'hffff;
      fr[0] = 1'b0;
      for (int i = 0; i < wl; i++) fr[i + 1] = dv[i];
      if (pb != 0) fr[wl + 1] = (^(dv & ((9'h001 << wl) - 9'h001))) ^ odd;
      return fr;
   endfunction
   // One register write; the response is accepted a few cycles late.
   task automatic axw(input logic [4:0] a, input logic [31:0] dv);
      logic ha, hw, ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         ta = ta | ha;
         tw = tw | hw;
      end
      while (!(ta && tw));
      repeat (3) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   // One register read; the data are accepted a cycle late.
   task automatic axr(input logic [4:0] a, output logic [31:0] dv, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      dv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // Prints the verdict and ends the run.
   task automatic print_verdict();
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      repeat (12000) @(posedge aclk);
      errors++;
      print_verdict();
   end
   // Main sequence.
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
      s_axi_awaddr <= 5'h00;
      s_axi_araddr <= 5'h00;
      s_axi_wdata <= 32'h0000_0000;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`REG_CTRL, v, r);
      chk(v, `CTRL_RESET);
      chk(v[`CTRL_MSB_WLEN:`CTRL_LSB_WLEN], 32'h0000_0008);
      chk(v[`CTRL_MAJ3], 1'b0);
      axr(`REG_BAUD, v, r);
      chk(v, {16'h0000, `BAUD_RESET});
      axr(5'h1c, v, r);
      chk({30'h0, r}, 32'h0000_0002);
      axw(5'h1c, 32'h0000_0000);
      chk({30'h0, br}, 32'h0000_0002);
      axw(`REG_BAUD, 32'h0000_0010);
      chk({30'h0, br}, 32'h0000_0000);
      // One frame per line format: bits, then the busy flag around the stop end.
      for (int i = 0; i < 5; i++)
      begin
         d = 9'h1a5 + 9'h033 * i[8:0];
         w = cfg[i][8:5];
         pe = cfg[i][2] && cfg[i][13:12] != `SUB_IRDA;
         n = w + pe + 2;
         axw(`REG_CTRL, {16'h0000, cfg[i]});
         axw(`REG_TXDATA, {23'h0, d});
         peer_uart_model_i.capture(n, got);
         chk(got, frame(d, w, pe, cfg[i][3]) & ((16'h1 << n) - 16'h1));
         repeat (8 * cfg[i][11:9] + 2) @(posedge aclk);
         axr(`REG_STATUS, v, r);
         chk(v[0], 1'b1);
         repeat (6) @(posedge aclk);
         axr(`REG_STATUS, v, r);
         chk(v[0], 1'b0);
      end
      // Transmit-done is pending but masked, then cleared by writing a one.
      @(negedge aclk);
      chk(irq, 1'b0);
      axr(`REG_INT_STAT, v, r);
      chk(v[`INT_TX_DONE], 1'b1);
      chk(v[`INT_COLLIDE], 1'b1);
      axw(`REG_INT_STAT, 32'h0000_0001);
      axr(`REG_INT_STAT, v, r);
      chk(v[`INT_TX_DONE], 1'b0);
      // Receive: glitch early in data bit 0, then that glitch with bad parity, then a mid-bit glitch under majority vote.
      axw(`REG_CTRL, 32'h0000_0107);
      axw(`REG_INT_MASK, 32'h0000_0001 << `INT_PAR_ERR);
      for (int i = 0; i < 3; i++)
      begin
         f = frame(9'h0c3 + i[8:0], 8, 1, 1'b0);
         if (i == 1) f[9] = ~f[9];
         if (i == 2) axw(`REG_CTRL, 32'h0000_0117);
         peer_uart_model_i.send(f, 11, i == 2 ? 4 : 1, i == 2 ? 8 : 2);
         repeat (4) @(posedge aclk);
         axr(`REG_RXDATA, v, r);
         if (i != 1) chk(v, 32'h0000_00c3 + i);
         @(negedge aclk);
         chk(irq, i == 1);
         if (i == 1) axw(`REG_INT_STAT, 32'h0000_00ff);
      end
      print_verdict();
   end
endmodule // test_uart_standard_frame_engine
